// ===== shared/trig_pin_pkg.sv
// constants and types for the trigger i/o pin
package trig_pin_pkg;
  // pin roles
  typedef enum logic [1:0] {ROLE_TRIGGER, ROLE_INPUT, ROLE_OUTPUT} role_t;
  // trigger direction within trigger role
  typedef enum logic {TDIR_OUT, TDIR_IN} tdir_t;
  // trigger-input target
  typedef enum logic [1:0] {TGT_MEASURE, TGT_DLOG, TGT_SEQUENCE} target_t;
  // general output drive selection
  typedef enum logic [1:0] {DRV_ZERO, DRV_ONE, DRV_PWM} drive_t;
  // sequence trigger source
  typedef enum logic {SEQ_SRC_MANUAL, SEQ_SRC_EXTERNAL} seq_src_t;
  // clock rate and pulse timing
  localparam int CLK_HZ = 25000000;
  localparam int LOW_TIME_US = 30;
  localparam int LOW_CYCLES = (LOW_TIME_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] LOW_CNT = CNT_W'(LOW_CYCLES);
  localparam int PWM_W = 16;
endpackage

// ===== shared/pwm_if.sv
// interface between pin top and pwm generator
`timescale 1ns/1ps
interface pwm_if #(parameter int W = 16);
  logic enable;
  logic [W-1:0] period;
  logic [W-1:0] high_time;
  logic wave;
  modport ctrl (output enable, output period, output high_time, input wave);
  modport gen (input enable, input period, input high_time, output wave);
endinterface

// ===== design/pwm_gen.sv
// pwm waveform generator with period and duty settings
`timescale 1ns/1ps
module pwm_gen #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  pwm_if.gen bus
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic wave;
  } pwm_state_t;

  pwm_state_t s_q;
  pwm_state_t s_d;

  // period counter and compare
  always_comb
  begin
    s_d = s_q;
    if (!bus.enable)
    begin
      s_d.cnt = '0;
      s_d.wave = 1'b0;
    end
    else
    begin
      if (s_q.cnt >= bus.period)
        s_d.cnt = '0;
      else
        s_d.cnt = s_q.cnt + 1'b1;
      s_d.wave = (s_d.cnt < bus.high_time);
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign bus.wave = s_q.wave;
endmodule

// ===== design/trigger_io_pin.sv
// one configurable trigger / level / output pin
`timescale 1ns/1ps
module trigger_io_pin #(
  parameter int PWM_W = trig_pin_pkg::PWM_W,
  parameter int CNT_W = trig_pin_pkg::CNT_W
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire trig_pin_pkg::role_t role_i,
  input wire trig_pin_pkg::tdir_t trig_dir_i,
  input wire trig_pin_pkg::target_t target_i,
  input wire trig_pin_pkg::drive_t drive_i,
  input wire trig_pin_pkg::seq_src_t sequence_trigger_source_i,
  input wire logic invert_i,
  input wire logic meas_arm_i,
  input wire logic trig_event_i,
  input wire logic panel_key_i,
  input wire logic [PWM_W-1:0] pwm_period_i,
  input wire logic [PWM_W-1:0] pwm_high_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic level_o,
  output logic meas_start_o,
  output logic dlog_start_o,
  output logic seq_start_o
);
  typedef struct packed {
    logic [CNT_W-1:0] low_cnt;
    logic pulsing;
    logic [CNT_W-1:0] in_cnt;
    logic in_seen;
    logic pin_out;
    logic pin_oe;
    logic level;
    logic meas;
    logic dlog;
    logic seq;
  } pin_state_t;

  pin_state_t s_q;
  pin_state_t s_d;
  logic pwm_wave;
  logic logic_in;
  logic trig_out_role;
  logic trig_in_role;
  logic fire;

  pwm_if #(.W(PWM_W)) pwm_bus ();

  //////////////////////////////////////////////////////////////////////////
  // pwm generator feed
  assign pwm_bus.enable = (role_i == trig_pin_pkg::ROLE_OUTPUT) &&
                          (drive_i == trig_pin_pkg::DRV_PWM);
  assign pwm_bus.period = pwm_period_i;
  assign pwm_bus.high_time = pwm_high_i;
  assign pwm_wave = pwm_bus.wave;

  pwm_gen #(.W(PWM_W)) u_pwm (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .bus(pwm_bus.gen)
  );

  //////////////////////////////////////////////////////////////////////////
  // role decode and event sources
  assign logic_in = pin_i ^ invert_i;
  assign trig_out_role = (role_i == trig_pin_pkg::ROLE_TRIGGER) &&
                         (trig_dir_i == trig_pin_pkg::TDIR_OUT);
  assign trig_in_role = (role_i == trig_pin_pkg::ROLE_TRIGGER) &&
                        (trig_dir_i == trig_pin_pkg::TDIR_IN);
  // internal trigger or manual-source panel key fires a pulse
  assign fire = trig_event_i ||
                (panel_key_i && (sequence_trigger_source_i ==
                                 trig_pin_pkg::SEQ_SRC_MANUAL));

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.meas = 1'b0;
    s_d.dlog = 1'b0;
    s_d.seq = 1'b0;
    s_d.pin_oe = 1'b0;
    s_d.pin_out = 1'b1;
    // panel key starts a manual-source sequence in any role
    if (panel_key_i && (sequence_trigger_source_i ==
                        trig_pin_pkg::SEQ_SRC_MANUAL))
      s_d.seq = 1'b1;
    case (role_i)
      trig_pin_pkg::ROLE_TRIGGER:
      begin
        if (trig_out_role)
        begin
          // low pulse timer, restarts on new event
          if (fire)
          begin
            s_d.pulsing = 1'b1;
            s_d.low_cnt = trig_pin_pkg::LOW_CNT;
          end
          else if (s_q.pulsing)
          begin
            if (s_q.low_cnt <= 16'h0001)
              s_d.pulsing = 1'b0;
            s_d.low_cnt = s_q.low_cnt - 1'b1;
          end
          s_d.pin_oe = 1'b1;
          s_d.pin_out = s_d.pulsing ~^ invert_i;
          s_d.in_cnt = trig_pin_pkg::CNT_RESET;
          s_d.in_seen = 1'b0;
        end
        else
        begin
          s_d.pulsing = 1'b0;
          s_d.low_cnt = trig_pin_pkg::CNT_RESET;
          // qualify a low of at least the minimum width
          if (logic_in)
          begin
            s_d.in_cnt = trig_pin_pkg::CNT_RESET;
            s_d.in_seen = 1'b0;
          end
          else if (!s_q.in_seen)
          begin
            s_d.in_cnt = s_q.in_cnt + 1'b1;
            if (s_d.in_cnt >= trig_pin_pkg::LOW_CNT)
            begin
              s_d.in_seen = 1'b1;
              case (target_i)
                trig_pin_pkg::TGT_MEASURE:
                  s_d.meas = meas_arm_i;
                trig_pin_pkg::TGT_DLOG:
                  s_d.dlog = 1'b1;
                // keep a panel-key start raised in the same cycle
                trig_pin_pkg::TGT_SEQUENCE:
                  s_d.seq = s_d.seq || (sequence_trigger_source_i ==
                            trig_pin_pkg::SEQ_SRC_EXTERNAL);
                default:
                  s_d.seq = s_d.seq;
              endcase
            end
          end
        end
      end
      trig_pin_pkg::ROLE_INPUT:
      begin
        s_d.level = logic_in;
        s_d.pulsing = 1'b0;
        s_d.in_seen = 1'b0;
        s_d.in_cnt = trig_pin_pkg::CNT_RESET;
      end
      trig_pin_pkg::ROLE_OUTPUT:
      begin
        s_d.pin_oe = 1'b1;
        s_d.pulsing = 1'b0;
        case (drive_i)
          trig_pin_pkg::DRV_ONE:
            s_d.pin_out = invert_i;
          trig_pin_pkg::DRV_ZERO:
            s_d.pin_out = ~invert_i;
          trig_pin_pkg::DRV_PWM:
            s_d.pin_out = pwm_wave ^ invert_i;
          default:
            s_d.pin_out = ~invert_i;
        endcase
      end
      default:
      begin
        s_d.pulsing = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '0;
      s_q.pin_out <= 1'b1;
      s_q.level <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // outputs from flip-flops
  assign pin_o = s_q.pin_out;
  assign pin_oe_o = s_q.pin_oe;
  assign level_o = s_q.level;
  assign meas_start_o = s_q.meas;
  assign dlog_start_o = s_q.dlog;
  assign seq_start_o = s_q.seq;
endmodule

// ===== verification/trig_pin_chk_assertions.sv
// checker for the trigger pin
`timescale 1ns/1ps
module trig_pin_chk (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire trig_pin_pkg::role_t role_i,
  input wire trig_pin_pkg::tdir_t trig_dir_i,
  input wire trig_pin_pkg::drive_t drive_i,
  input wire trig_pin_pkg::seq_src_t sequence_trigger_source_i,
  input wire logic invert_i,
  input wire logic meas_arm_i,
  input wire logic trig_event_i,
  input wire logic panel_key_i,
  input wire logic pin_i,
  input wire logic pin_o,
  input wire logic pin_oe_o,
  input wire logic level_o,
  input wire logic meas_start_o,
  input wire logic dlog_start_o,
  input wire logic seq_start_o
);
  // trigger role pointing outwards
  wire tout = role_i == trig_pin_pkg::ROLE_TRIGGER &&
    trig_dir_i == trig_pin_pkg::TDIR_OUT;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////
  trig_out_a: assert property (tout && trig_event_i |=>
    pin_oe_o && pin_o == $past(invert_i)) else $error("no pin pulse");
  low_hold_a: assert property (tout && !invert_i && $rose(pin_o) |->
    !$past(pin_o, trig_pin_pkg::LOW_CYCLES)) else $error("pulse short");
  drive_lvl_a: assert property (
    role_i == trig_pin_pkg::ROLE_OUTPUT && drive_i != trig_pin_pkg::DRV_PWM
    |=> pin_oe_o && pin_o == ($past(invert_i) ^
    ($past(drive_i) == trig_pin_pkg::DRV_ZERO))) else $error("bad drive");
  in_level_a: assert property (
    role_i == trig_pin_pkg::ROLE_INPUT |=>
    !pin_oe_o && level_o == ($past(pin_i) ^ $past(invert_i)))
    else $error("bad level");
  // active level depends on polarity, so compare against it
  start_len_a: assert property (meas_start_o || dlog_start_o |->
    !($past(pin_i, trig_pin_pkg::LOW_CYCLES) ^
    $past(invert_i, trig_pin_pkg::LOW_CYCLES))) else $error("short start");
  meas_arm_a: assert property (meas_start_o |-> $past(meas_arm_i))
    else $error("start unarmed");
  seq_src_a: assert property (seq_start_o |-> $past(panel_key_i) ||
    $past(sequence_trigger_source_i) == trig_pin_pkg::SEQ_SRC_EXTERNAL)
    else $error("bad sequence start");
  panel_key_a: assert property (panel_key_i &&
    sequence_trigger_source_i == trig_pin_pkg::SEQ_SRC_MANUAL
    |=> seq_start_o) else $error("key ignored");
  // main scenarios reached
  cover property (tout && trig_event_i);
  cover property (meas_start_o);
  cover property (dlog_start_o);
  cover property (seq_start_o);
endmodule
bind trigger_io_pin trig_pin_chk i_chk (.*);

// ===== verification/ext_equip.sv
// external equipment with pull-up on the pin
`timescale 1ns/1ps
module ext_equip (
  input wire logic clock_i,
  input wire logic dev_level_i,
  input wire logic dev_oe_i,
  output logic pin_level_o
);
  logic drv_q = 1'b0;
  logic val_q = 1'b1;
  // device wins while driving, else equipment, else pull-up
  assign pin_level_o = dev_oe_i ? dev_level_i : (drv_q ? val_q : 1'b1);
  // hold the active level for n whole cycles
  task automatic pulse(input int n, input logic inv);
    @(negedge clock_i);
    val_q = inv;
    drv_q = 1'b1;
    repeat (n) @(negedge clock_i);
    drv_q = 1'b0;
  endtask
endmodule

// ===== verification/tb_trigger_io_pin.sv
// self-checking bench for the trigger pin
`timescale 1ns/1ps
module tb_trigger_io_pin;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  trig_pin_pkg::role_t role = trig_pin_pkg::ROLE_TRIGGER;
  trig_pin_pkg::tdir_t dir = trig_pin_pkg::TDIR_OUT;
  trig_pin_pkg::target_t tgt = trig_pin_pkg::TGT_MEASURE;
  trig_pin_pkg::drive_t drv = trig_pin_pkg::DRV_ZERO;
  trig_pin_pkg::seq_src_t src = trig_pin_pkg::SEQ_SRC_MANUAL;
  logic inv = 1'b0;
  logic arm = 1'b0;
  logic ev = 1'b0;
  logic key = 1'b0;
  logic [15:0] per = 16'h0003;
  logic [15:0] hi = 16'h0001;
  logic pin_o, oe, lvl, ms, ds, ss;
  wire pin_w;
  logic [2:0] seen;
  int ones;
  int failures = 0;
  int tests_run = 0;
  always #20 clock_i = ~clock_i;
  trigger_io_pin i_dut (.clock_i, .rst_b_i, .role_i(role), .trig_dir_i(dir),
    .target_i(tgt), .drive_i(drv), .sequence_trigger_source_i(src),
    .invert_i(inv), .meas_arm_i(arm), .trig_event_i(ev), .panel_key_i(key),
    .pwm_period_i(per), .pwm_high_i(hi), .pin_i(pin_w), .pin_o,
    .pin_oe_o(oe), .level_o(lvl), .meas_start_o(ms), .dlog_start_o(ds),
    .seq_start_o(ss));
  ext_equip i_eq (.clock_i, .dev_level_i(pin_o), .dev_oe_i(oe),
    .pin_level_o(pin_w));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // pulse from outside, collect {measure, log, sequence} starts
  task automatic trig_in(input trig_pin_pkg::target_t t, input logic a,
    input trig_pin_pkg::seq_src_t s, input int n, output logic [2:0] got);
    @(negedge clock_i);
    tgt = t;
    arm = a;
    src = s;
    got = 3'h0;
    fork
      i_eq.pulse(n, 1'b0);
      repeat (n + 8)
      begin
        @(negedge clock_i);
        got = got | {ms, ds, ss};
      end
    join
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    // reset levels: pin released high, level high, no starts
    chk(16'({oe, pin_o, lvl, ms, ds, ss}), 16'h0018);
    rst_b_i = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      inv = i[0];
      repeat (2) @(negedge clock_i);
      ev = 1'b1;
      @(negedge clock_i);
      ev = 1'b0;
      chk(16'({oe, pin_o}), 16'({1'b1, inv}));
      repeat (749) @(negedge clock_i);
      chk(16'(pin_o), 16'(inv));
      @(negedge clock_i);
      chk(16'(pin_o), 16'(!inv));
    end
    key = 1'b1;
    @(negedge clock_i);
    key = 1'b0;
    chk(16'({ss, pin_o}), 16'h0003);
    repeat (760) @(negedge clock_i);
    dir = trig_pin_pkg::TDIR_IN;
    @(negedge clock_i);
    inv = 1'b0;
    trig_in(trig_pin_pkg::TGT_MEASURE, 1'b0, src, 750, seen);
    chk(16'(seen), 16'h0000);
    trig_in(trig_pin_pkg::TGT_MEASURE, 1'b1, src, 749, seen);
    chk(16'(seen), 16'h0000);
    trig_in(trig_pin_pkg::TGT_MEASURE, 1'b1, src, 750, seen);
    chk(16'(seen), 16'h0004);
    trig_in(trig_pin_pkg::TGT_DLOG, 1'b0, src, 750, seen);
    chk(16'(seen), 16'h0002);
    trig_in(trig_pin_pkg::TGT_SEQUENCE, 1'b0, src, 750, seen);
    chk(16'(seen), 16'h0000);
    trig_in(trig_pin_pkg::TGT_SEQUENCE, 1'b0,
      trig_pin_pkg::SEQ_SRC_EXTERNAL, 750, seen);
    chk(16'(seen), 16'h0001);
    role = trig_pin_pkg::ROLE_OUTPUT;
    for (int i = 0; i < 4; i++)
    begin
      inv = i[1];
      drv = i[0] ? trig_pin_pkg::DRV_ONE : trig_pin_pkg::DRV_ZERO;
      repeat (2) @(negedge clock_i);
      chk(16'({oe, pin_o}), 16'({1'b1, i[1] ^ ~i[0]}));
    end
    inv = 1'b0;
    drv = trig_pin_pkg::DRV_PWM;
    repeat (4) @(negedge clock_i);
    ones = 0;
    repeat (8)
    begin
      @(negedge clock_i);
      ones += int'(pin_o);
    end
    chk(16'(ones), 16'h0002);
    role = trig_pin_pkg::ROLE_INPUT;
    repeat (2) @(negedge clock_i);
    chk(16'({oe, lvl}), 16'h0001);
    fork
      i_eq.pulse(4, 1'b0);
      repeat (3) @(negedge clock_i);
    join_any
    chk(16'(lvl), 16'h0000);
    repeat (4) @(negedge clock_i);
    inv = 1'b1;
    repeat (2) @(negedge clock_i);
    chk(16'(lvl), 16'h0000);
    finish_test();
  end
  // cut a hang short
  initial
  begin
    #1000000;
    failures++;
    finish_test();
  end
endmodule
